// ### rtl/wts_pkg.sv
// Constants, register map and field layout of the watchdog service block
package wts_pkg;
  // ==========================================================
  // Bus
  localparam int AXI_DW = 32;
  localparam int AXI_SW = AXI_DW / 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_RELOAD_MODULUS   = 4'h0;
  localparam logic [3:0] IDX_WATCHDOG_CONTROL = 4'h2;
  localparam logic [3:0] IDX_SERVICE_KEY      = 4'h4;
  localparam logic [3:0] IDX_COUNT_VIEW       = 4'h6;
  localparam int         IDX_LSB              = 2;

  // ==========================================================
  // Control register fields
  localparam int CTL_EN    = 0;
  localparam int CTL_CU    = 1;
  localparam int CTL_IE    = 2;
  localparam int CTL_IF    = 3;
  localparam int CTL_SEL   = 4;
  localparam int CTL_IS    = 7;
  localparam int CTL_DBG   = 8;
  localparam int CTL_STOP  = 9;
  localparam int CTL_DOZE  = 10;
  localparam int CTL_WAIT  = 11;

  // ==========================================================
  // Reset values and keys
  localparam logic [15:0] MODULUS_RST = 16'hffff;
  localparam logic [15:0] KEY_FIRST   = 16'h5555;
  localparam logic [15:0] KEY_SECOND  = 16'haaaa;
  localparam logic [2:0]  SEL_RST     = 3'h0;

  // ==========================================================
  // Timing
  localparam int          CLK_HZ      = 100_000_000;
  localparam int          WD_SRC_HZ   = 128_000;
  localparam int          BASE_DIV    = CLK_HZ / WD_SRC_HZ;
  localparam logic [11:0] PRE_DIV_MAX = 12'h800;

  // Mode pin order
  localparam int MODE_WAIT  = 0;
  localparam int MODE_DOZE  = 1;
  localparam int MODE_STOP  = 2;
  localparam int MODE_DEBUG = 3;
endpackage

// ### rtl/wts_watchdog.sv
// Watchdog down-counter with key service sequence, behind an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
// What this block does
// - Four registers at indices 0,2,4,6; user access to first two errors.
// - Modulus write loads counter at once and serves later reloads; resets 0xffff.
// - Completed service sequence reloads the 16-bit counter from stored modulus.
// - Wait, doze, stop halt bits set by reset; one halts counting in mode.
// - Debug halt bit stops counting in debug; registers stay accessible.
// - Toggling debug halt bit inside debug starts or stops the counter.
// - Read-only pending status bit is 1 while interrupt status is uncleared.
// - Divider select picks 128 kHz over 2048 down to over 16.
// - Writing one to the interrupt flag clears it.
// - Interrupt enable selects interrupt mode; cleared by hardware on interrupt.
// - Commit bit copies divider select and modulus into working latches.
// - Enable bit starts counting; zero keeps the watchdog disabled.
// - Missed service raises system reset or interrupt.
// - Other bus traffic between the two keys does not break the sequence.
// - Any other value written restarts the service sequence.
// - Count register reads live count; writes ignored without error.
// - Counter counts down freely and times out on underflow.
// - After a stop halt, counting resumes from the held state.
module wts_watchdog #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // AXI4-Lite write address
  input  wire logic [AW-1:0]                  s_axi_awaddr,
  input  wire logic [2:0]                     s_axi_awprot,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [wts_pkg::AXI_DW-1:0]     s_axi_wdata,
  input  wire logic [wts_pkg::AXI_SW-1:0]     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AW-1:0]                  s_axi_araddr,
  input  wire logic [2:0]                     s_axi_arprot,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  // AXI4-Lite read data
  output logic [wts_pkg::AXI_DW-1:0]          s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // Processor power and debug modes
  input  wire logic                           wait_mode,
  input  wire logic                           doze_mode,
  input  wire logic                           stop_mode,
  input  wire logic                           debug_mode,
  // Timeout outputs
  output logic                                wdt_irq,
  output logic                                wdt_sys_reset
);
  import wts_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0]        modulus_value;
    logic [15:0]        work_modulus;
    logic [15:0]        live_count;
    logic [2:0]         tick_divider_select;
    logic [2:0]         work_select;
    logic               enable;
    logic               irq_mode_enable;
    logic               irq_flag;
    logic               halt_in_debugger;
    logic               halt_in_stop;
    logic               halt_in_doze;
    logic               halt_in_wait;
    logic               commit_pending;
    logic               key_armed;
    logic [9:0]         base_cnt;
    logic [10:0]        pre_cnt;
    logic [3:0]         mode_s1;
    logic [3:0]         mode_s2;
    logic [3:0]         mode_s3;
    logic [3:0]         modes;
    logic               sys_reset;
    logic               aw_have;
    logic               w_have;
    logic [AW-1:0]      awaddr;
    logic               awpriv;
    logic [AXI_DW-1:0]  wdata;
    logic [AXI_SW-1:0]  wstrb;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [AXI_DW-1:0]  rdata;
  } wts_state_t;

  wts_state_t s_q;
  wts_state_t s_d;

  // ==========================================================
  // Helpers
  // Decode a byte address to a register index; unmapped gives 0 valid
  function automatic logic decode_hit(input logic [AW-1:0] addr, input logic [3:0] idx);
    decode_hit = (addr == AW'({idx, 2'h0}) << (IDX_LSB - 2));
  endfunction

  function automatic logic mapped(input logic [AW-1:0] addr);
    mapped = decode_hit(addr, IDX_RELOAD_MODULUS) | decode_hit(addr, IDX_WATCHDOG_CONTROL) |
             decode_hit(addr, IDX_SERVICE_KEY) | decode_hit(addr, IDX_COUNT_VIEW);
  endfunction

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] control_view(input wts_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[CTL_EN]             = s.enable;
    v[CTL_IE]             = s.irq_mode_enable;
    v[CTL_IF]             = s.irq_flag;
    v[CTL_SEL +: 3]       = s.tick_divider_select;
    v[CTL_IS]             = s.irq_flag;
    v[CTL_DBG]            = s.halt_in_debugger;
    v[CTL_STOP]           = s.halt_in_stop;
    v[CTL_DOZE]           = s.halt_in_doze;
    v[CTL_WAIT]           = s.halt_in_wait;
    control_view = v;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic        do_write;
    logic        wr_mod;
    logic        wr_ctl;
    logic        wr_key;
    logic        priv_only;
    logic [15:0] wval;
    logic [15:0] cval;
    logic        halted;
    logic        base_tick;
    logic        cnt_tick;
    logic [10:0] pre_last;
    do_write  = 1'b0;
    wr_mod    = 1'b0;
    wr_ctl    = 1'b0;
    wr_key    = 1'b0;
    priv_only = 1'b0;
    wval      = 16'h0000;
    cval      = 16'h0000;
    halted    = 1'b0;
    base_tick = 1'b0;
    cnt_tick  = 1'b0;
    pre_last  = 11'h000;
    s_d       = s_q;

    // Mode pins: three flops, change taken once the last two agree
    s_d.mode_s1 = {debug_mode, stop_mode, doze_mode, wait_mode};
    s_d.mode_s2 = s_q.mode_s1;
    s_d.mode_s3 = s_q.mode_s2;
    // Old value held while stages differ, so a metastable sample never counts
    s_d.modes   = (s_q.mode_s3 & ~(s_q.mode_s2 ^ s_q.mode_s3)) |
                  (s_q.modes & (s_q.mode_s2 ^ s_q.mode_s3));

    // ---------------- write channel
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
      s_d.awpriv  = s_axi_awprot[0];
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      priv_only   = decode_hit(s_q.awaddr, IDX_RELOAD_MODULUS) |
                    decode_hit(s_q.awaddr, IDX_WATCHDOG_CONTROL);
      if (!mapped(s_q.awaddr)) begin
        s_d.bresp = RESP_DECERR;
      end else if (priv_only && !s_q.awpriv) begin
        s_d.bresp = RESP_SLVERR;
      end else begin
        s_d.bresp = RESP_OKAY;
        do_write  = 1'b1;
      end
    end
    wr_mod = do_write && decode_hit(s_q.awaddr, IDX_RELOAD_MODULUS);
    wr_ctl = do_write && decode_hit(s_q.awaddr, IDX_WATCHDOG_CONTROL);
    wr_key = do_write && decode_hit(s_q.awaddr, IDX_SERVICE_KEY);
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // ---------------- read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = '0;
      s_d.rresp  = RESP_OKAY;
      if (!mapped(s_axi_araddr)) begin
        s_d.rresp = RESP_DECERR;
      end else if ((decode_hit(s_axi_araddr, IDX_RELOAD_MODULUS) ||
                    decode_hit(s_axi_araddr, IDX_WATCHDOG_CONTROL)) && !s_axi_arprot[0]) begin
        s_d.rresp = RESP_SLVERR;
      end else if (decode_hit(s_axi_araddr, IDX_RELOAD_MODULUS)) begin
        s_d.rdata[15:0] = s_q.modulus_value;
      end else if (decode_hit(s_axi_araddr, IDX_WATCHDOG_CONTROL)) begin
        s_d.rdata[15:0] = control_view(s_q);
      end else if (decode_hit(s_axi_araddr, IDX_COUNT_VIEW)) begin
        s_d.rdata[15:0] = s_q.live_count;
      end
    end
    s_d.arready = !s_d.rvalid;

    // ---------------- register effects
    if (wr_mod) begin
      wval              = merge16(s_q.modulus_value, s_q.wdata, s_q.wstrb);
      s_d.modulus_value = wval;
      s_d.work_modulus  = wval;
      s_d.live_count    = wval;
      s_d.pre_cnt       = '0;
    end
    if (wr_ctl) begin
      cval                    = merge16(control_view(s_q), s_q.wdata, s_q.wstrb);
      s_d.enable              = cval[CTL_EN];
      s_d.irq_mode_enable     = cval[CTL_IE];
      s_d.tick_divider_select = cval[CTL_SEL +: 3];
      s_d.halt_in_debugger    = cval[CTL_DBG];
      s_d.halt_in_stop        = cval[CTL_STOP];
      s_d.halt_in_doze        = cval[CTL_DOZE];
      s_d.halt_in_wait        = cval[CTL_WAIT];
      if (cval[CTL_IF] && s_q.wstrb[0]) begin
        s_d.irq_flag = 1'b0;
      end
      // commit taken at next watchdog tick
      if (cval[CTL_CU] && s_q.wstrb[0]) begin
        s_d.commit_pending = 1'b1;
      end
    end
    if (wr_key) begin
      wval = (s_q.wstrb[1:0] == 2'h3) ? s_q.wdata[15:0] : 16'h0000;
      if (wval == KEY_FIRST) begin
        s_d.key_armed = 1'b1;
      end else if (wval == KEY_SECOND && s_q.key_armed) begin
        s_d.key_armed  = 1'b0;
        s_d.live_count = s_q.work_modulus;
        s_d.pre_cnt    = '0;
      end else if (wval != KEY_SECOND) begin
        s_d.key_armed = 1'b0;
      end
    end

    // ---------------- watchdog rate
    // only the commit lands on 128 kHz enable edges; other bus effects land at once
    base_tick    = (s_q.base_cnt == 10'(BASE_DIV - 1));
    s_d.base_cnt = base_tick ? 10'h000 : s_q.base_cnt + 10'h001;
    // Counting pauses while a commit waits, so old and new divisors never mix
    if (base_tick && s_q.commit_pending) begin
      s_d.commit_pending = 1'b0;
      s_d.work_select    = s_q.tick_divider_select;
      s_d.work_modulus   = s_q.modulus_value;
      s_d.pre_cnt        = '0;
    end

    // Prescaler phase is kept over a halt, so resuming loses no time
    // mode halts
    halted = (s_q.modes[MODE_WAIT]  && s_q.halt_in_wait) ||
             (s_q.modes[MODE_DOZE]  && s_q.halt_in_doze) ||
             (s_q.modes[MODE_STOP]  && s_q.halt_in_stop) ||
             (s_q.modes[MODE_DEBUG] && s_q.halt_in_debugger);

    // divide by 2048 shifted down by select
    pre_last = 11'((PRE_DIV_MAX >> s_q.work_select) - 12'h001);
    if (base_tick && s_q.enable && !halted && !s_q.commit_pending && !wr_mod && !wr_key) begin
      if (s_q.pre_cnt == pre_last) begin
        s_d.pre_cnt = '0;
        cnt_tick    = 1'b1;
      end else begin
        s_d.pre_cnt = s_q.pre_cnt + 11'h001;
      end
    end

    if (cnt_tick) begin
      if (s_q.live_count == 16'h0000) begin
        s_d.live_count = s_q.work_modulus;
        if (s_q.irq_mode_enable) begin
          s_d.irq_flag        = 1'b1;
          s_d.irq_mode_enable = 1'b0;
        end else begin
          // reset mode
          // Request stays up until bus reset; the reset controller releases it
          s_d.sys_reset = 1'b1;
        end
      end else begin
        s_d.live_count = s_q.live_count - 16'h0001;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q                     <= '0;
      s_q.modulus_value       <= MODULUS_RST;
      s_q.work_modulus        <= MODULUS_RST;
      s_q.live_count          <= MODULUS_RST;
      s_q.tick_divider_select <= SEL_RST;
      s_q.work_select         <= SEL_RST;
      s_q.halt_in_stop        <= 1'b1;
      s_q.halt_in_doze        <= 1'b1;
      s_q.halt_in_wait        <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flop
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = s_q.rdata;
  assign wdt_irq       = s_q.irq_flag;
  assign wdt_sys_reset = s_q.sys_reset;
endmodule

// ### test/wts_watchdog_properties.sv
// Concurrent checks on the watchdog block's bus answers and timeout outputs
`timescale 1ns/1ns
module wts_watchdog_properties
  import wts_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Write side
  input wire logic [AW-1:0]              s_axi_awaddr,
  input wire logic [2:0]                 s_axi_awprot,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  // Read side
  input wire logic [AW-1:0]              s_axi_araddr,
  input wire logic [2:0]                 s_axi_arprot,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [wts_pkg::AXI_DW-1:0] s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  // Timeout outputs
  input wire logic                       wdt_irq,
  input wire logic                       wdt_sys_reset
);
  // ==========================================================
  // Helpers
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  function automatic logic sup_only(input logic [AW-1:0] a);
    return a == AW'({IDX_RELOAD_MODULUS, 2'h0}) || a == AW'({IDX_WATCHDOG_CONTROL, 2'h0});
  endfunction
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  sequence wr_user_s;
    wr_take && !s_axi_awprot[0] && sup_only(s_axi_awaddr);
  endsequence
  sequence wr_count_s;
    wr_take && s_axi_awaddr == AW'({IDX_COUNT_VIEW, 2'h0});
  endsequence
  // ==========================================================
  // Properties
  chk_user_wr_err: assert property (wr_user_s
    |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
    else $error("user write to supervisor register not refused");
  chk_user_rd_err: assert property (rd_take && !s_axi_arprot[0] && sup_only(s_axi_araddr)
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("user read of supervisor register not refused");
  chk_unmapped_rd: assert property (rd_take && s_axi_araddr >= AW'(8'h1c)
    |=> s_axi_rvalid && s_axi_rresp == RESP_DECERR)
    else $error("unmapped read not decode error");
  chk_rdata_stand: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed before taken");
  chk_count_wr_ok: assert property (wr_count_s
    |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_OKAY))
    else $error("count write not answered okay");
  chk_irq_clear: assert property ($fell(wdt_irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt flag fell without a write");
  chk_rst_sticky: assert property (wdt_sys_reset |=> wdt_sys_reset)
    else $error("system reset request released early");
  chk_timeout_excl: assert property ($rose(wdt_sys_reset) |-> !$rose(wdt_irq))
    else $error("reset and interrupt raised together");
endmodule
bind wts_watchdog wts_watchdog_properties #(.AW(AW)) wts_watchdog_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wdt_irq(wdt_irq),
  .wdt_sys_reset(wdt_sys_reset)
);

// ### test/wts_watchdog_tb.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ns
module wts_watchdog_tb;
  import wts_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [7:0] A_MOD = {2'h0, IDX_RELOAD_MODULUS, 2'h0};
  localparam logic [7:0] A_CTL = {2'h0, IDX_WATCHDOG_CONTROL, 2'h0};
  localparam logic [7:0] A_SRV = {2'h0, IDX_SERVICE_KEY, 2'h0};
  localparam logic [7:0] A_CNT = {2'h0, IDX_COUNT_VIEW, 2'h0};
  // One count step at the fastest divider
  localparam int TICK = BASE_DIV * 16;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        wait_m = 1'b0, doze_m = 1'b0, stop_m = 1'b0, dbg_m = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, srst;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [34:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [34:0] er;
  logic [15:0] v, m;
  int          n_fail = 0, total_checks = 0;
  always #5 aclk = ~aclk;
  wts_watchdog #(.AW(8)) wts_watchdog_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wait_mode(wait_m),
    .doze_mode(doze_m), .stop_mode(stop_m), .debug_mode(dbg_m), .wdt_irq(irq),
    .wdt_sys_reset(srst)
  );
  // ==========================================================
  // Reporting
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic note(input logic ok, input logic [33:0] e, g);
    total_checks++;
    if (!ok) begin
      n_fail++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_rd(input logic [33:0] e, g);
    note(g === e, e, g);
  endtask
  task automatic cmp_b(input logic [1:0] e, g);
    note(g === e, 34'(e), 34'(g));
  endtask
  task automatic cmp_flag(input logic e, g);
    note(g === e, 34'(e), 34'(g));
  endtask
  task automatic guard(input int n, lim);
    if (n >= lim) begin
      n_fail++;
      $display("mismatch at %0t: wait limit %h reached at %h", $time, lim, n);
      finish_test();
    end
  endtask
  // Control word: halts {wait,doze,stop,debug}, divider, irq mode, commit, enable
  function automatic logic [15:0] ctlw(input logic [3:0] hd, input logic [2:0] s,
                                       input logic ie, cu, en);
    return {4'h0, hd, 1'b0, s, 1'b0, ie, cu, en};
  endfunction
  // ==========================================================
  // Bus master; answer ready comes late at random to stall the slave
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic sup,
                    input logic [1:0] r);
    int n;
    int st;
    st = $urandom_range(0, 3);
    exp_b.push_back(r);
    awaddr <= a;
    awprot <= {2'h0, sup};
    wdata <= {16'h0, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bready && bvalid === 1'b1) break;
      if (n == st) bready <= 1'b1;
    end
    bready <= 1'b0;
    guard(n, 200);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic sup, chk, input logic [15:0] d,
                    input logic [1:0] r, output logic [15:0] got);
    int n;
    int st;
    st = $urandom_range(0, 3);
    exp_r.push_back({chk, 16'h0, d, r});
    araddr <= a;
    arprot <= {2'h0, sup};
    arvalid <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rready && rvalid === 1'b1) break;
      if (n == st) rready <= 1'b1;
    end
    got = rdata[15:0];
    rready <= 1'b0;
    guard(n, 200);
    @(posedge aclk);
  endtask
  // Each answer is matched against the oldest expectation
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) begin
      er = exp_r.pop_front();
      cmp_rd(er[33:0], {er[34] ? rdata : er[33:2], rresp});
    end
    if (bvalid === 1'b1 && bready) begin
      cmp_b(exp_b.pop_front(), bresp);
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    int n;
    void'($urandom(32'h3e42c932));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_MOD, 1, 1, MODULUS_RST, RESP_OKAY, v);
    rd(A_CTL, 1, 1, 16'h0e00, RESP_OKAY, v);
    rd(A_CNT, 0, 1, 16'hffff, RESP_OKAY, v);
    $display("test reset values done");
    rd(A_MOD, 0, 1, 16'h0, RESP_SLVERR, v);
    wr(A_CTL, 16'h0001, 0, RESP_SLVERR);
    rd(A_CTL, 1, 1, 16'h0e00, RESP_OKAY, v);
    rd(8'h1c, 1, 0, 16'h0, RESP_DECERR, v);
    rd(A_SRV, 0, 1, 16'h0, RESP_OKAY, v);
    wr(A_CNT, 16'h1234, 1, RESP_OKAY);
    rd(A_CNT, 1, 1, 16'hffff, RESP_OKAY, v);
    $display("test access rules done");
    m = 16'($urandom);
    wr(A_MOD, m, 1, RESP_OKAY);
    rd(A_MOD, 1, 1, m, RESP_OKAY, v);
    rd(A_CNT, 1, 1, m, RESP_OKAY, v);
    $display("test modulus load done");
    // Halted in wait, doze, stop and debug; the count must hold over a full step
    stop_m <= 1'b1;
    dbg_m <= 1'b1;
    wait_m <= 1'b1;
    doze_m <= 1'b1;
    wr(A_MOD, 16'h0005, 1, RESP_OKAY);
    wr(A_CTL, ctlw(4'hf, 3'h7, 0, 1, 1), 1, RESP_OKAY);
    repeat (TICK + 800) @(posedge aclk);
    rd(A_CNT, 1, 1, 16'h0005, RESP_OKAY, v);
    rd(A_CTL, 1, 1, ctlw(4'hf, 3'h7, 0, 0, 1), RESP_OKAY, v);
    stop_m <= 1'b0;
    wr(A_CTL, ctlw(4'h2, 3'h7, 0, 0, 1), 1, RESP_OKAY);
    // Reread until the count leaves 5
    v = 16'h0005;
    for (n = 0; n < TICK && v === 16'h0005; n++) rd(A_CNT, 1, 0, 16'h0, RESP_OKAY, v);
    guard(n, TICK);
    rd(A_CNT, 1, 1, 16'h0004, RESP_OKAY, v);
    $display("test halt and debug done");
    wr(A_SRV, KEY_FIRST, 0, RESP_OKAY);
    wr(A_SRV, 16'h1234, 1, RESP_OKAY);
    wr(A_SRV, KEY_SECOND, 1, RESP_OKAY);
    rd(A_CNT, 1, 1, 16'h0004, RESP_OKAY, v);
    wr(A_SRV, KEY_FIRST, 0, RESP_OKAY);
    wr(A_CNT, 16'h0000, 0, RESP_OKAY);
    rd(A_CTL, 1, 0, 16'h0, RESP_OKAY, v);
    wr(A_SRV, KEY_SECOND, 0, RESP_OKAY);
    rd(A_CNT, 1, 1, 16'h0005, RESP_OKAY, v);
    $display("test service sequence done");
    // Modulus zero gives the shortest timeout
    wr(A_CTL, ctlw(4'h2, 3'h7, 1, 0, 1), 1, RESP_OKAY);
    wr(A_MOD, 16'h0000, 1, RESP_OKAY);
    for (n = 0; n < 2 * TICK && irq !== 1'b1; n++) @(posedge aclk);
    guard(n, 2 * TICK);
    cmp_flag(1'b0, srst);
    m = ctlw(4'h2, 3'h7, 0, 0, 1) | (16'h1 << CTL_IF);
    rd(A_CTL, 1, 1, m | (16'h1 << CTL_IS), RESP_OKAY, v);
    wr(A_CTL, m, 1, RESP_OKAY);
    cmp_flag(1'b0, irq);
    rd(A_CTL, 1, 1, ctlw(4'h2, 3'h7, 0, 0, 1), RESP_OKAY, v);
    $display("test interrupt timeout done");
    for (n = 0; n < 2 * TICK && srst !== 1'b1; n++) @(posedge aclk);
    guard(n, 2 * TICK);
    cmp_flag(1'b0, irq);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_flag(1'b0, srst);
    $display("test reset timeout done");
    for (int s = 0; s < 8; s++) begin
      wr(A_CTL, ctlw(4'he, 3'(s), 0, 0, 0), 1, RESP_OKAY);
      rd(A_CTL, 1, 1, ctlw(4'he, 3'(s), 0, 0, 0), RESP_OKAY, v);
    end
    $display("test divider codes done");
    finish_test();
  end
endmodule
